// file: core/iss_defs.vh
`ifndef ISS_DEFS_VH
`define ISS_DEFS_VH
// ----------------------------------------
// slave addresses, 7 bit
// ----------------------------------------
`define ISS_ACC_ADDR_LO 7'h18
`define ISS_ACC_ADDR_HI 7'h19
`define ISS_GYR_ADDR_LO 7'h68
`define ISS_GYR_ADDR_HI 7'h69
// ----------------------------------------
// reset values
// ----------------------------------------
`define ISS_PTR_RST 8'h00
// ----------------------------------------
// write record fields {part, addr, data}
// ----------------------------------------
`define ISS_REC_W 17
`define ISS_REC_PART 16
`define ISS_FIFO_DEPTH 16
// ----------------------------------------
// i2c engine states
// ----------------------------------------
`define ISS_I_IDLE 3'h0
`define ISS_I_ADDR 3'h1
`define ISS_I_ACK 3'h2
`define ISS_I_PTR 3'h3
`define ISS_I_WDAT 3'h4
`define ISS_I_RDAT 3'h5
`define ISS_I_MACK 3'h6
`define ISS_I_IGN 3'h7
`endif

// file: core/iss_top.v
`timescale 1ns/1ps
`include "iss_defs.vh"

// ----------------------------------------
// input synchroniser, three stages
// ----------------------------------------
module iss_sync #(
  parameter W = 1
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q_r
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
      q_r <= {W{1'b1}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // change counts only once two stages agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ----------------------------------------
// write record fifo
// ----------------------------------------
module iss_fifo #(
  parameter W = 17,
  parameter AW = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output reg out_valid_r,
  output reg [W-1:0] out_data_r,
  input wire out_ready
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire empty = (wp_r == rp_r);
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign in_ready = ~full;
  always @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_r <= {W{1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      // output stage refills when empty or when taken
      if (!out_valid_r || out_ready) begin
        if (!empty) begin
          out_data_r <= mem[rp_r[AW-1:0]];
          out_valid_r <= 1'b1;
          rp_r <= rp_r + 1'b1;
        end else begin
          out_valid_r <= 1'b0;
        end
      end
    end
  end
endmodule

// ----------------------------------------
// serial slave top
// ----------------------------------------
module iss_top #(
  parameter FIFO_AW = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire scl_sck_i,
  input wire sda_sdi_i,
  output reg sda_o_r,
  output reg sda_oe_r,
  input wire accel_chip_select_n,
  input wire accel_serial_out_or_addr_strap_i,
  output reg accel_serial_out_or_addr_strap_o_r,
  output reg accel_serial_out_or_addr_strap_oe_r,
  input wire gyro_serial_out_or_addr_strap_i,
  output reg [7:0] rd_addr_r,
  output reg rd_part_r,
  input wire [7:0] rd_data,
  output wire wr_valid,
  output wire wr_part,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  input wire wr_ready,
  output reg spi_mode_r
);
  // ----------------------------------------
  // synchronised pins and edges
  // ----------------------------------------
  wire [4:0] pins_f;
  iss_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({gyro_serial_out_or_addr_strap_i, accel_serial_out_or_addr_strap_i,
        accel_chip_select_n, sda_sdi_i, scl_sck_i}),
    .q_r(pins_f)
  );
  wire scl_f = pins_f[0];
  wire sda_f = pins_f[1];
  wire csb_f = pins_f[2];
  wire strap_a = pins_f[3];
  wire strap_g = pins_f[4];
  reg scl_p_r;
  reg sda_p_r;
  reg csb_p_r;
  wire scl_rise = scl_f & ~scl_p_r;
  wire scl_fall = ~scl_f & scl_p_r;
  wire i_start = scl_f & scl_p_r & sda_p_r & ~sda_f;
  wire i_stop = scl_f & scl_p_r & ~sda_p_r & sda_f;
  wire csb_fall = ~csb_f & csb_p_r;
  wire csb_rise = csb_f & ~csb_p_r;

  // ----------------------------------------
  // write records
  // ----------------------------------------
  reg push_r;
  reg [`ISS_REC_W-1:0] push_data_r;
  wire fifo_ready;
  wire [`ISS_REC_W-1:0] rec;
  iss_fifo #(.W(`ISS_REC_W), .AW(FIFO_AW)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push_r),
    .in_data(push_data_r),
    .in_ready(fifo_ready),
    .out_valid_r(wr_valid),
    .out_data_r(rec),
    .out_ready(wr_ready)
  );
  assign wr_part = rec[`ISS_REC_PART];
  assign wr_addr = rec[15:8];
  assign wr_data = rec[7:0];

  // ----------------------------------------
  // i2c state
  // ----------------------------------------
  reg [2:0] ist_r;
  reg [2:0] inext_r;
  reg [3:0] icnt_r;
  reg [7:0] ish_r;
  reg [7:0] itx_r;
  reg low_seen_r;
  reg more_r;
  reg [7:0] start_a_r;
  reg [7:0] start_g_r;
  // accel strap address, lost in spi mode
  wire acc_hit = ~spi_mode_r &&
    (ish_r[7:1] == (strap_a ? `ISS_ACC_ADDR_HI : `ISS_ACC_ADDR_LO));
  wire gyr_hit = (ish_r[7:1] == (strap_g ? `ISS_GYR_ADDR_HI : `ISS_GYR_ADDR_LO));

  // ----------------------------------------
  // spi state
  // ----------------------------------------
  reg [4:0] scnt_r;
  reg [7:0] ssh_r;
  reg [7:0] stx_r;
  reg srw_r;
  reg cpol_r;
  wire spi_on = spi_mode_r & ~csb_f;
  wire [7:0] sbyte = {ssh_r[6:0], sda_f};

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      csb_p_r <= 1'b1;
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
      accel_serial_out_or_addr_strap_o_r <= 1'b0;
      accel_serial_out_or_addr_strap_oe_r <= 1'b0;
      rd_addr_r <= `ISS_PTR_RST;
      rd_part_r <= 1'b0;
      spi_mode_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= {`ISS_REC_W{1'b0}};
      ist_r <= `ISS_I_IDLE;
      inext_r <= `ISS_I_IDLE;
      icnt_r <= 4'h0;
      ish_r <= 8'h00;
      itx_r <= 8'h00;
      low_seen_r <= 1'b0;
      more_r <= 1'b0;
      start_a_r <= `ISS_PTR_RST;
      start_g_r <= `ISS_PTR_RST;
      scnt_r <= 5'h00;
      ssh_r <= 8'h00;
      stx_r <= 8'h00;
      srw_r <= 1'b0;
      cpol_r <= 1'b0;
    end else begin
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
      csb_p_r <= csb_f;
      push_r <= 1'b0;
      // sticky switch to spi until reset
      if (csb_rise) begin
        spi_mode_r <= 1'b1;
      end
      accel_serial_out_or_addr_strap_oe_r <= spi_on;
      // ----- spi framing -----
      if (csb_fall) begin
        // idle sck level picks mode 00 or 11
        cpol_r <= scl_f;
        scnt_r <= 5'h00;
      end else if (spi_on && scl_rise) begin
        ssh_r <= sbyte;
        scnt_r <= (scnt_r == 5'd23) ? 5'd16 : scnt_r + 5'd1;
        if (scnt_r == 5'd7) begin
          srw_r <= sbyte[7];
          rd_addr_r <= {1'b0, sbyte[6:0]};
          rd_part_r <= 1'b0;
        end else if ((scnt_r == 5'd15 || scnt_r == 5'd23) && !srw_r) begin
          // write data from bit 8 on
          push_r <= 1'b1;
          push_data_r <= {1'b0, rd_addr_r, sbyte};
          rd_addr_r <= rd_addr_r + 8'h01;
        end else if (scnt_r == 5'd23 && srw_r) begin
          rd_addr_r <= rd_addr_r + 8'h01;
        end
      end else if (spi_on && scl_fall && !(cpol_r && scnt_r == 5'h00)) begin
        if (scnt_r == 5'd16) begin
          // data only after the filler byte
          stx_r <= {rd_data[6:0], 1'b0};
          accel_serial_out_or_addr_strap_o_r <= rd_data[7];
        end else begin
          stx_r <= {stx_r[6:0], 1'b0};
          accel_serial_out_or_addr_strap_o_r <= stx_r[7];
        end
      end
      // ----- i2c framing -----
      if (~scl_f) begin
        low_seen_r <= 1'b1;
      end
      if (i_start) begin
        ist_r <= `ISS_I_ADDR;
        icnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        low_seen_r <= 1'b0;
      end else if (i_stop && ist_r != `ISS_I_IDLE) begin
        // stop with no scl low since start is ignored
        if (low_seen_r) begin
          ist_r <= `ISS_I_IDLE;
          sda_oe_r <= 1'b0;
        end
      end else begin
        case (ist_r)
          `ISS_I_ADDR, `ISS_I_PTR, `ISS_I_WDAT: begin
            if (scl_rise) begin
              ish_r <= {ish_r[6:0], sda_f};
              icnt_r <= icnt_r + 4'h1;
            end else if (scl_fall && icnt_r == 4'h8) begin
              icnt_r <= 4'h0;
              if (ist_r == `ISS_I_ADDR) begin
                // only a seven bit address is compared
                if (acc_hit || gyr_hit) begin
                  sda_oe_r <= 1'b1;
                  ist_r <= `ISS_I_ACK;
                  rd_part_r <= gyr_hit;
                  inext_r <= ish_r[0] ? `ISS_I_RDAT : `ISS_I_PTR;
                  if (ish_r[0]) begin
                    // read starts at last written pointer
                    rd_addr_r <= gyr_hit ? start_g_r : start_a_r;
                  end
                end else begin
                  // no ack, wait for next start
                  ist_r <= `ISS_I_IGN;
                end
              end else if (ist_r == `ISS_I_PTR) begin
                sda_oe_r <= 1'b1;
                ist_r <= `ISS_I_ACK;
                inext_r <= `ISS_I_WDAT;
                rd_addr_r <= ish_r;
                if (rd_part_r) begin
                  start_g_r <= ish_r;
                end else begin
                  start_a_r <= ish_r;
                end
              end else if (fifo_ready) begin
                sda_oe_r <= 1'b1;
                ist_r <= `ISS_I_ACK;
                inext_r <= `ISS_I_WDAT;
                push_r <= 1'b1;
                push_data_r <= {rd_part_r, rd_addr_r, ish_r};
                rd_addr_r <= rd_addr_r + 8'h01;
              end else begin
                // full record buffer: refuse byte
                ist_r <= `ISS_I_IGN;
              end
            end
          end
          `ISS_I_ACK: begin
            if (scl_fall) begin
              ist_r <= inext_r;
              if (inext_r == `ISS_I_RDAT) begin
                itx_r <= {rd_data[6:0], 1'b0};
                sda_oe_r <= ~rd_data[7];
              end else begin
                sda_oe_r <= 1'b0;
              end
            end
          end
          `ISS_I_RDAT: begin
            if (scl_rise) begin
              icnt_r <= icnt_r + 4'h1;
            end else if (scl_fall) begin
              if (icnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                icnt_r <= 4'h0;
                ist_r <= `ISS_I_MACK;
              end else begin
                itx_r <= {itx_r[6:0], 1'b0};
                sda_oe_r <= ~itx_r[7];
              end
            end
          end
          `ISS_I_MACK: begin
            if (scl_rise) begin
              more_r <= ~sda_f;
              // pointer steps after each byte sent
              rd_addr_r <= rd_addr_r + 8'h01;
            end else if (scl_fall) begin
              if (more_r) begin
                itx_r <= {rd_data[6:0], 1'b0};
                sda_oe_r <= ~rd_data[7];
                ist_r <= `ISS_I_RDAT;
              end else begin
                // nack ends read, sda stays released
                sda_oe_r <= 1'b0;
                ist_r <= `ISS_I_IGN;
              end
            end
          end
          `ISS_I_IGN: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            ist_r <= `ISS_I_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: bench/iss_top_properties.sv
`timescale 1ns/1ps
// ------------
// port checker
// ------------
module iss_top_chk (
  input wire mclk,
  input wire sys_rst,
  input wire scl_sck_i,
  input wire sda_o_r,
  input wire sda_oe_r,
  input wire accel_chip_select_n,
  input wire accel_serial_out_or_addr_strap_o_r,
  input wire accel_serial_out_or_addr_strap_oe_r,
  input wire wr_valid,
  input wire wr_ready,
  input wire spi_mode_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_sda_low_only: assert property (sda_oe_r |-> !sda_o_r)
    else $error("sda driven high");
  a_sdo_i2c_quiet: assert property (!spi_mode_r |-> !accel_serial_out_or_addr_strap_oe_r)
    else $error("sdo driven in i2c");
  a_mode_sticky: assert property (spi_mode_r |=> spi_mode_r)
    else $error("spi mode lost");
  a_mode_cause: assert property ($rose(spi_mode_r) |->
    accel_chip_select_n && $past(accel_chip_select_n, 2))
    else $error("spi mode without cs rise");
  a_sdo_release: assert property ((spi_mode_r && accel_chip_select_n) [*8] |=>
    !accel_serial_out_or_addr_strap_oe_r)
    else $error("sdo held after cs");
  a_sdo_edge: assert property (!accel_chip_select_n &&
    $changed(accel_serial_out_or_addr_strap_o_r) |-> !scl_sck_i)
    else $error("sdo moved with sck high");
  a_rec_hold: assert property (wr_valid && !wr_ready |=> wr_valid)
    else $error("record dropped");
  a_ack_stable: assert property (scl_sck_i [*6] |=> $stable(sda_oe_r))
    else $error("sda moved with scl high");
endmodule

bind iss_top iss_top_chk u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .scl_sck_i(scl_sck_i), .sda_o_r(sda_o_r),
  .sda_oe_r(sda_oe_r), .accel_chip_select_n(accel_chip_select_n),
  .accel_serial_out_or_addr_strap_o_r(accel_serial_out_or_addr_strap_o_r),
  .accel_serial_out_or_addr_strap_oe_r(accel_serial_out_or_addr_strap_oe_r),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .spi_mode_r(spi_mode_r)
);

// file: bench/iss_host.sv
`timescale 1ns/1ps
// ------------
// host master
// ------------
module iss_host (
  output reg scl = 1'b1,
  output reg sda_m = 1'b1,
  output reg cs_n = 1'b1,
  input wire sda_w,
  input wire sdo_w
);
  // 320 ns bit: input sync plus drive lag exceeds 80 ns
  localparam Q = 80;
  integer i;
  task start;
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask
  // start then stop, scl never low
  task glitch;
    #Q sda_m = 1'b0;
    #Q sda_m = 1'b1;
    #Q scl = 1'b0;
  endtask
  task stop;
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #2000;
  endtask
  // msb first, ack seen in high phase
  task wbyte(input [7:0] v, output ack);
    for (i = 7; i >= 0; i = i - 1) begin
      #Q sda_m = v[i];
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
    end
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q ack = !sda_w;
    #Q scl = 1'b0;
  endtask
  // master ack or nack per byte
  task rbyte(input mack, output [7:0] v);
    for (i = 7; i >= 0; i = i - 1) begin
      #Q sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q v[i] = sda_w;
      #Q scl = 1'b0;
    end
    #Q sda_m = !mack;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
  endtask
  // sck idle level set before select
  task sel(input lvl, input idle);
    scl = idle;
    #(2 * Q) cs_n = lvl;
    #(2 * Q);
  endtask
  // drive after fall, sample on rise
  task sbyte(input [7:0] v, output [7:0] r);
    for (i = 7; i >= 0; i = i - 1) begin
      scl = 1'b0;
      #Q sda_m = v[i];
      #Q scl = 1'b1;
      #Q r[i] = sdo_w;
      #Q;
    end
  endtask
endmodule

// file: bench/iss_top_bench.sv
`timescale 1ns/1ps
// ------------
// bench
// ------------
module iss_top_bench;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg hold = 1'b1;
  reg wr_ready = 1'b0;
  reg [1:0] strap = 2'h0;
  reg [7:0] mem [0:511];
  reg [16:0] exp_q [$];
  reg [7:0] b, d;
  reg a;
  integer seed = 32'h1fe7;
  integer n_fail = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer j, k, rnd;
  wire scl, sda_m, cs_n, sdo_o, sdo_oe, sda_o, sda_oe, wr_valid, wr_part, rd_part, spi_mode;
  wire [7:0] rd_addr, wr_addr, wr_data;
  // pulled-up sda; a released sdo pin shows its strap
  wire sda_w = sda_m & ~(sda_oe & ~sda_o);
  wire sdo_w = sdo_oe ? sdo_o : strap[0];
  iss_host h (.scl(scl), .sda_m(sda_m), .cs_n(cs_n), .sda_w(sda_w), .sdo_w(sdo_w));
  iss_top i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_sck_i(scl), .sda_sdi_i(sda_w),
    .sda_o_r(sda_o), .sda_oe_r(sda_oe), .accel_chip_select_n(cs_n),
    .accel_serial_out_or_addr_strap_i(sdo_w), .accel_serial_out_or_addr_strap_o_r(sdo_o),
    .accel_serial_out_or_addr_strap_oe_r(sdo_oe), .gyro_serial_out_or_addr_strap_i(strap[1]),
    .rd_addr_r(rd_addr), .rd_part_r(rd_part), .rd_data(mem[{rd_part, rd_addr}]),
    .wr_valid(wr_valid), .wr_part(wr_part), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ready(wr_ready), .spi_mode_r(spi_mode)
  );
  function [7:0] slave_w(input part, input s);
    slave_w = {part ? 6'h34 : 6'h0c, s, 1'b0};
  endfunction
  task check(input [16:0] seen, input [16:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task drain;
    hold = 1'b0;
    repeat (400) if (exp_q.size() > 0) @(negedge mclk);
    check(exp_q.size() == 0, 1'b1);
  endtask
  initial forever #10 mclk = ~mclk;
  always @(negedge mclk) begin
    rnd = $random(seed);
    wr_ready <= !hold && rnd[0];
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
    if (wr_valid === 1'b1 && wr_ready)
      check({wr_part, wr_addr, wr_data}, exp_q.pop_front());
  end
  initial begin
    for (j = 0; j < 512; j = j + 1) mem[j] = $random(seed);
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    check(spi_mode, 1'b0);
    h.start;
    h.wbyte(8'h31, a);
    h.rbyte(1'b1, b);
    check(b, mem[0]);
    h.rbyte(1'b0, b);
    check(b, mem[1]);
    h.stop;
    check(sda_oe, 1'b0);
    h.glitch;
    h.wbyte(8'h30, a);
    check(a, 1'b1);
    h.wbyte(8'h40, a);
    // output register holds one record beyond the 16 buffered
    for (j = 0; j < 18; j = j + 1) begin
      d = j ? $random(seed) : 8'ha8;
      if (j < 17) exp_q.push_back({1'b0, 8'h40 + j[7:0], d});
      h.wbyte(d, a);
      check(a, j < 17);
    end
    h.stop;
    drain;
    for (k = 0; k < 4; k = k + 1) begin
      strap = {k[1], k[1]};
      d = $random(seed);
      exp_q.push_back({k[0], 8'h20, d});
      h.start;
      h.wbyte(slave_w(k[0], k[1]), a);
      check(a, 1'b1);
      h.wbyte(8'h20, a);
      h.wbyte(d, a);
      h.stop;
      h.start;
      h.wbyte(slave_w(k[0], !k[1]), a);
      check(a, 1'b0);
      h.wbyte(8'h21, a);
      check(a, 1'b0);
      h.stop;
    end
    drain;
    strap = 2'h0;
    h.start;
    h.wbyte(8'hd1, a);
    h.rbyte(1'b0, b);
    h.stop;
    check(b, mem[9'h120]);
    h.start;
    h.wbyte(8'h30, a);
    h.wbyte(8'h12, a);
    h.start;
    h.wbyte(8'h31, a);
    for (j = 0; j < 6; j = j + 1) begin
      h.rbyte(j < 5, b);
      check(b, mem[8'h12 + j]);
    end
    h.stop;
    check(sda_oe, 1'b0);
    h.start;
    h.wbyte(8'h31, a);
    h.rbyte(1'b0, b);
    h.stop;
    check(b, mem[8'h12]);
    h.sel(1'b0, 1'b0);
    h.sel(1'b1, 1'b0);
    check(spi_mode, 1'b1);
    for (k = 0; k < 2; k = k + 1) begin
      h.sel(1'b0, k[0]);
      h.sbyte(8'h92, b);
      for (j = 0; j < 7; j = j + 1) begin
        d = $random(seed);
        h.sbyte(d, b);
        if (j > 0) check(b, mem[8'h11 + j]);
      end
      h.sel(1'b1, k[0]);
    end
    d = $random(seed);
    exp_q.push_back({9'h005, d});
    exp_q.push_back({9'h006, ~d});
    h.sel(1'b0, 1'b0);
    h.sbyte(8'h05, b);
    h.sbyte(d, b);
    h.sbyte(~d, b);
    h.sel(1'b1, 1'b0);
    drain;
    h.start;
    h.wbyte(8'h30, a);
    h.stop;
    check(a, 1'b0);
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    check(spi_mode, 1'b0);
    h.start;
    h.wbyte(8'h31, a);
    h.rbyte(1'b0, b);
    h.stop;
    check(a, 1'b1);
    check(b, mem[0]);
    give_verdict;
  end
endmodule
